//--- core/fspc_pkg.sv
package fspc_pkg;

  // ==========================================================
  // Opcodes
  localparam logic [7:0] OP_DEEP_SLEEP = 8'hB9;
  localparam logic [7:0] OP_DEEP_WAKE = 8'hAB;
  localparam logic [7:0] OP_ULTRA_SLEEP = 8'h79;
  localparam logic [7:0] OP_STATUS_READ = 8'hD7;
  localparam logic [7:0] OP_CFG_B0 = 8'h3D;
  localparam logic [7:0] OP_CFG_B1 = 8'h2A;
  localparam logic [7:0] OP_CFG_B2 = 8'h80;
  localparam logic [7:0] OP_CFG_256 = 8'hA6;
  localparam logic [7:0] OP_CFG_264 = 8'hA7;

  // ==========================================================
  // Frame layout
  localparam int CMD_BYTES = 4;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [2:0] BYTES_OP = 3'h1;
  localparam logic [2:0] BYTES_CFG = 3'h4;
  localparam logic [3:0] STATUS_LAST_BIT = 4'hF;

  // ==========================================================
  // Status word: byte 1 in [15:8], byte 2 in [7:0]
  localparam int ST_RDY_B1 = 15;
  localparam int ST_PAGE_B1 = 8;
  localparam int ST_RDY_B2 = 7;
  localparam logic STATUS_PAGE_264 = 1'b0;
  localparam logic STATUS_PAGE_256 = 1'b1;
  localparam logic STATUS_BUSY = 1'b0;
  localparam logic STATUS_READY = 1'b1;

  // ==========================================================
  // Timing, times in ns
  localparam int CLK_MHZ = 250;
  localparam int NS_PER_US = 1000;
  localparam int DEEP_SLEEP_ENTRY_TIME_NS = 3000;
  localparam int DEEP_SLEEP_EXIT_TIME_NS = 35000;
  localparam int ULTRA_SLEEP_ENTRY_TIME_NS = 3000;
  localparam int ULTRA_SLEEP_EXIT_TIME_NS = 180000;
  localparam int CONFIG_PROGRAM_TIME_NS = 4000000;
  localparam int TIMER_W = 32;

  // ==========================================================
  // Power and configuration states
  typedef enum logic [7:0] {
    FSPC_STANDBY = 8'h01,
    FSPC_ENTER_DEEP = 8'h02,
    FSPC_DEEP = 8'h04,
    FSPC_EXIT_DEEP = 8'h08,
    FSPC_ENTER_ULTRA = 8'h10,
    FSPC_ULTRA = 8'h20,
    FSPC_EXIT_ULTRA = 8'h40,
    FSPC_PROGRAM = 8'h80
  } fspc_state_t;

endpackage

//--- core/fspc_sync.sv
`timescale 1ns/1ns
// ==========================================================
// Two-stage synchroniser for pin inputs
module fspc_sync #(
  parameter int WIDTH = 3
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [WIDTH-1:0] async_in,
  input wire logic [WIDTH-1:0] reset_val,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;

  // First stage feeds only the second stage
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      meta_reg <= reset_val; // Idle pin levels, so no false edge follows reset
      sync_out <= reset_val;
    end else if (clk_en) begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule

//--- core/fspc_timer.sv
`timescale 1ns/1ns
// ==========================================================
// Down-counter for self-timed intervals
module fspc_timer #(
  parameter int WIDTH = 32
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic load,
  input wire logic [WIDTH-1:0] load_val,
  output logic done
);
  logic [WIDTH-1:0] cnt_reg;

  // Done fires once, in the cycle the count runs out
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt_reg <= '0;
      done <= 1'b0;
    end else if (clk_en) begin
      done <= 1'b0;
      if (load) begin
        cnt_reg <= load_val;
      end else if (cnt_reg != '0) begin
        cnt_reg <= cnt_reg - 1'b1;
        done <= (cnt_reg == {{(WIDTH-1){1'b0}}, 1'b1});
      end
    end
  end
endmodule

//--- core/fspc_top.sv
`timescale 1ns/1ns
module fspc_top #(
  parameter int T_DEEP_ENTRY_NS = fspc_pkg::DEEP_SLEEP_ENTRY_TIME_NS,
  parameter int T_DEEP_EXIT_NS = fspc_pkg::DEEP_SLEEP_EXIT_TIME_NS,
  parameter int T_ULTRA_ENTRY_NS = fspc_pkg::ULTRA_SLEEP_ENTRY_TIME_NS,
  parameter int T_ULTRA_EXIT_NS = fspc_pkg::ULTRA_SLEEP_EXIT_TIME_NS,
  parameter int T_CFG_PROG_NS = fspc_pkg::CONFIG_PROGRAM_TIME_NS
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic spi_cs_n,
  input wire logic spi_sck,
  input wire logic spi_si,
  output logic spi_so,
  output logic spi_so_oe_n,
  input wire logic array_busy,
  input wire logic nv_page_256,
  output logic nv_prog_stb,
  output logic nv_prog_val,
  output logic page_size_256,
  output logic ready,
  output logic low_power_standby,
  output logic deep_sleep,
  output logic ultra_sleep,
  output logic buffer_lost,
  output logic buffer_valid
);

  // ==========================================================
  // Cycle counts; maximum times round down, never below one cycle
  function automatic logic [fspc_pkg::TIMER_W-1:0] cyc_floor(input int t_ns);
    longint c;
    c = longint'(t_ns) * fspc_pkg::CLK_MHZ / fspc_pkg::NS_PER_US;
    if (c < 1) begin
      c = 1;
    end
    return c[fspc_pkg::TIMER_W-1:0];
  endfunction

  localparam logic [fspc_pkg::TIMER_W-1:0] CYC_DEEP_ENTRY = cyc_floor(T_DEEP_ENTRY_NS);
  localparam logic [fspc_pkg::TIMER_W-1:0] CYC_DEEP_EXIT = cyc_floor(T_DEEP_EXIT_NS);
  localparam logic [fspc_pkg::TIMER_W-1:0] CYC_ULTRA_ENTRY = cyc_floor(T_ULTRA_ENTRY_NS);
  localparam logic [fspc_pkg::TIMER_W-1:0] CYC_ULTRA_EXIT = cyc_floor(T_ULTRA_EXIT_NS);
  localparam logic [fspc_pkg::TIMER_W-1:0] CYC_CFG_PROG = cyc_floor(T_CFG_PROG_NS);

  // ==========================================================
  // Pin synchronisers and edge detection
  logic [2:0] pins_s;
  logic cs_n_s;
  logic sck_s;
  logic si_s;
  logic cs_n_q_reg;
  logic sck_q_reg;

  fspc_sync #(
    .WIDTH(3)
  ) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .clk_en(clk_en),
    .async_in({spi_cs_n, spi_sck, spi_si}),
    .reset_val(3'h4),
    .sync_out(pins_s)
  );

  assign cs_n_s = pins_s[2];
  assign sck_s = pins_s[1];
  assign si_s = pins_s[0];

  // Delayed copies of the synchronised pins; reset to idle levels
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cs_n_q_reg <= 1'b1;
      sck_q_reg <= 1'b0;
    end else if (clk_en) begin
      cs_n_q_reg <= cs_n_s;
      sck_q_reg <= sck_s;
    end
  end

  logic cs_fall;
  logic cs_rise;
  logic sck_rise;
  logic sck_fall;

  // Edge logic reads only the second stage and its delayed copy
  assign cs_fall = cs_n_q_reg & ~cs_n_s;
  assign cs_rise = ~cs_n_q_reg & cs_n_s;
  assign sck_rise = ~cs_n_s & ~sck_q_reg & sck_s;
  assign sck_fall = ~cs_n_s & sck_q_reg & ~sck_s;

  // ==========================================================
  // Frame receiver
  logic [7:0] rx_shift_reg;
  logic [2:0] bit_cnt_reg;
  logic [2:0] byte_cnt_reg;
  logic [7:0] cmd_mem [fspc_pkg::CMD_BYTES];
  logic [7:0] rx_byte;
  logic byte_done;

  assign rx_byte = {rx_shift_reg[6:0], si_s};
  assign byte_done = sck_rise && (bit_cnt_reg == fspc_pkg::LAST_BIT);

  // Counters restart at each frame; bytes past the fourth are dropped
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rx_shift_reg <= '0;
      bit_cnt_reg <= '0;
      byte_cnt_reg <= '0;
    end else if (clk_en) begin
      if (cs_fall) begin
        bit_cnt_reg <= '0;
        byte_cnt_reg <= '0;
      end else if (sck_rise) begin
        rx_shift_reg <= rx_byte;
        bit_cnt_reg <= bit_cnt_reg + 1'b1;
        if (byte_done && byte_cnt_reg != fspc_pkg::BYTES_CFG) begin
          byte_cnt_reg <= byte_cnt_reg + 1'b1;
        end
      end
    end
  end

  // Command bytes kept by index for decode at frame end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int i = 0; i < fspc_pkg::CMD_BYTES; i++) begin
        cmd_mem[i] <= '0;
      end
    end else if (clk_en && byte_done && byte_cnt_reg != fspc_pkg::BYTES_CFG) begin
      cmd_mem[byte_cnt_reg[1:0]] <= rx_byte;
    end
  end

  // Single opcode seen in full; trailing bytes do not matter
  function automatic logic op_is(input logic [7:0] op);
    return (byte_cnt_reg >= fspc_pkg::BYTES_OP) && (cmd_mem[0] == op);
  endfunction

  // Four-byte configuration sequence seen in full
  function automatic logic cfg_is(input logic [7:0] last);
    return (byte_cnt_reg == fspc_pkg::BYTES_CFG) && (cmd_mem[0] == fspc_pkg::OP_CFG_B0)
      && (cmd_mem[1] == fspc_pkg::OP_CFG_B1) && (cmd_mem[2] == fspc_pkg::OP_CFG_B2)
      && (cmd_mem[3] == last);
  endfunction

  // ==========================================================
  // Power state machine
  fspc_pkg::fspc_state_t state_reg;
  logic frame_void_reg;
  logic timer_load;
  logic [fspc_pkg::TIMER_W-1:0] timer_val;
  logic timer_done;
  logic awake;
  logic frame_end;

  assign awake = (state_reg == fspc_pkg::FSPC_STANDBY) || (state_reg == fspc_pkg::FSPC_PROGRAM);
  assign frame_end = cs_rise && !frame_void_reg;

  // Frames begun in entry, exit or ultra states are void, even if standby comes mid-frame;
  // deep sleep frames stay valid so that the wake opcode can still be decoded
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      frame_void_reg <= 1'b0;
    end else if (clk_en && cs_fall) begin
      frame_void_reg <= !awake && (state_reg != fspc_pkg::FSPC_DEEP);
    end
  end

  // Sleep and configuration opcodes act only at chip select rise
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_reg <= fspc_pkg::FSPC_STANDBY;
    end else if (clk_en) begin
      unique case (state_reg)
        fspc_pkg::FSPC_STANDBY: begin
          if (frame_end && !array_busy) begin
            if (op_is(fspc_pkg::OP_DEEP_SLEEP)) begin
              state_reg <= fspc_pkg::FSPC_ENTER_DEEP;
            end else if (op_is(fspc_pkg::OP_ULTRA_SLEEP)) begin
              state_reg <= fspc_pkg::FSPC_ENTER_ULTRA;
            end else if (cfg_is(fspc_pkg::OP_CFG_256) || cfg_is(fspc_pkg::OP_CFG_264)) begin
              state_reg <= fspc_pkg::FSPC_PROGRAM;
            end
          end
        end
        fspc_pkg::FSPC_ENTER_DEEP: begin
          if (timer_done) begin
            state_reg <= fspc_pkg::FSPC_DEEP;
          end
        end
        fspc_pkg::FSPC_DEEP: begin
          if (frame_end && op_is(fspc_pkg::OP_DEEP_WAKE)) begin
            state_reg <= fspc_pkg::FSPC_EXIT_DEEP;
          end
        end
        fspc_pkg::FSPC_EXIT_DEEP: begin
          if (timer_done) begin
            state_reg <= fspc_pkg::FSPC_STANDBY;
          end
        end
        fspc_pkg::FSPC_ENTER_ULTRA: begin
          if (timer_done) begin
            state_reg <= fspc_pkg::FSPC_ULTRA;
          end
        end
        fspc_pkg::FSPC_ULTRA: begin
          // Any select pulse wakes; its content is never decoded
          if (cs_rise) begin
            state_reg <= fspc_pkg::FSPC_EXIT_ULTRA;
          end
        end
        fspc_pkg::FSPC_EXIT_ULTRA: begin
          if (timer_done) begin
            state_reg <= fspc_pkg::FSPC_STANDBY;
          end
        end
        fspc_pkg::FSPC_PROGRAM: begin
          if (timer_done) begin
            state_reg <= fspc_pkg::FSPC_STANDBY;
          end
        end
        default: begin
          state_reg <= fspc_pkg::FSPC_STANDBY;
        end
      endcase
    end
  end

  // Timer start values, loaded on the transition that begins each interval
  always_comb begin
    timer_load = 1'b0;
    timer_val = CYC_DEEP_ENTRY;
    if (state_reg == fspc_pkg::FSPC_STANDBY && frame_end && !array_busy) begin
      if (op_is(fspc_pkg::OP_DEEP_SLEEP)) begin
        timer_load = 1'b1;
      end else if (op_is(fspc_pkg::OP_ULTRA_SLEEP)) begin
        timer_load = 1'b1;
        timer_val = CYC_ULTRA_ENTRY;
      end else if (cfg_is(fspc_pkg::OP_CFG_256) || cfg_is(fspc_pkg::OP_CFG_264)) begin
        timer_load = 1'b1;
        timer_val = CYC_CFG_PROG;
      end
    end else if (state_reg == fspc_pkg::FSPC_DEEP && frame_end
                 && op_is(fspc_pkg::OP_DEEP_WAKE)) begin
      timer_load = 1'b1;
      timer_val = CYC_DEEP_EXIT;
    end else if (state_reg == fspc_pkg::FSPC_ULTRA && cs_rise) begin
      timer_load = 1'b1;
      timer_val = CYC_ULTRA_EXIT;
    end
  end

  fspc_timer #(
    .WIDTH(fspc_pkg::TIMER_W)
  ) u_timer (
    .clk_sys(clk_sys),
    .rst(rst),
    .clk_en(clk_en),
    .load(timer_load),
    .load_val(timer_val),
    .done(timer_done)
  );

  // ==========================================================
  // Page size configuration
  logic strap_taken_reg;
  logic pending_256_reg;

  // Stored setting is caught once after reset, then follows completed programs
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      strap_taken_reg <= 1'b0;
      page_size_256 <= 1'b0;
      pending_256_reg <= 1'b0;
    end else if (clk_en) begin
      if (!strap_taken_reg) begin
        strap_taken_reg <= 1'b1;
        page_size_256 <= nv_page_256;
      end else if (state_reg == fspc_pkg::FSPC_PROGRAM && timer_done) begin
        page_size_256 <= pending_256_reg;
      end
      if (timer_load && state_reg == fspc_pkg::FSPC_STANDBY) begin
        pending_256_reg <= cfg_is(fspc_pkg::OP_CFG_256);
      end
    end
  end

  // Nonvolatile cell write, pulsed as programming starts
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      nv_prog_stb <= 1'b0;
      nv_prog_val <= 1'b0;
    end else if (clk_en) begin
      nv_prog_stb <= timer_load && state_reg == fspc_pkg::FSPC_STANDBY
        && timer_val == CYC_CFG_PROG && frame_end
        && (cfg_is(fspc_pkg::OP_CFG_256) || cfg_is(fspc_pkg::OP_CFG_264));
      if (timer_load && state_reg == fspc_pkg::FSPC_STANDBY) begin
        nv_prog_val <= cfg_is(fspc_pkg::OP_CFG_256);
      end
    end
  end

  // ==========================================================
  // Status read
  logic status_on_reg;
  logic [3:0] tx_cnt_reg;
  logic [15:0] status_word;

  // Live word: bits refresh on every pass, so polling sees busy end
  always_comb begin
    status_word = '0;
    status_word[fspc_pkg::ST_RDY_B1] = ready ? fspc_pkg::STATUS_READY : fspc_pkg::STATUS_BUSY;
    status_word[fspc_pkg::ST_RDY_B2] = ready ? fspc_pkg::STATUS_READY : fspc_pkg::STATUS_BUSY;
    status_word[fspc_pkg::ST_PAGE_B1] = page_size_256 ? fspc_pkg::STATUS_PAGE_256
                                                      : fspc_pkg::STATUS_PAGE_264;
  end

  // Only awake, valid frames may start a status read
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      status_on_reg <= 1'b0;
      tx_cnt_reg <= '0;
      spi_so <= 1'b0;
    end else if (clk_en) begin
      if (cs_n_s || !awake) begin
        status_on_reg <= 1'b0;
        tx_cnt_reg <= '0;
      end else if (byte_done && byte_cnt_reg == '0 && !frame_void_reg
                   && rx_byte == fspc_pkg::OP_STATUS_READ) begin
        status_on_reg <= 1'b1;
        tx_cnt_reg <= '0;
      end else if (status_on_reg && sck_fall) begin
        spi_so <= status_word[fspc_pkg::STATUS_LAST_BIT - tx_cnt_reg];
        tx_cnt_reg <= tx_cnt_reg + 1'b1;
      end
    end
  end

  // Output driven only during a status read in an awake state
  assign spi_so_oe_n = !(status_on_reg && awake && !cs_n_s);

  // ==========================================================
  // Buffer contents tracking
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      buffer_lost <= 1'b0;
      buffer_valid <= 1'b1;
    end else if (clk_en) begin
      buffer_lost <= (state_reg == fspc_pkg::FSPC_ENTER_ULTRA) && timer_done;
      if (state_reg == fspc_pkg::FSPC_ENTER_ULTRA && timer_done) begin
        buffer_valid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Power status outputs
  assign ready = (state_reg != fspc_pkg::FSPC_PROGRAM) && !array_busy;
  assign low_power_standby = (state_reg == fspc_pkg::FSPC_STANDBY) && cs_n_s
                             && !array_busy;
  assign deep_sleep = (state_reg == fspc_pkg::FSPC_DEEP);
  assign ultra_sleep = (state_reg == fspc_pkg::FSPC_ULTRA);

endmodule

//--- test/fspc_assertions.sv
`timescale 1ns/1ns
// ==========================================================
// Port checker for the sleep and page size controller
module fspc_assertions (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic spi_cs_n,
  input wire logic spi_so_oe_n,
  input wire logic array_busy,
  input wire logic nv_prog_stb,
  input wire logic nv_prog_val,
  input wire logic page_size_256,
  input wire logic ready,
  input wire logic low_power_standby,
  input wire logic deep_sleep,
  input wire logic ultra_sleep,
  input wire logic buffer_lost,
  input wire logic buffer_valid
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Program cycle: strobe, then a busy stretch far longer than the frame end
  sequence s_prog_start;
    nv_prog_stb;
  endsequence
  sequence s_busy_hold;
    !ready [*8];
  endsequence
  property p_reset_standby;
    $fell(rst) |-> !deep_sleep && !ultra_sleep && buffer_valid;
  endproperty
  a_reset_standby: assert property (p_reset_standby) else $error("sleep after reset");
  property p_sleep_hiz;
    deep_sleep || ultra_sleep |-> spi_so_oe_n;
  endproperty
  a_sleep_hiz: assert property (p_sleep_hiz) else $error("output driven in sleep");
  property p_sleep_cs;
    $rose(deep_sleep) || $rose(ultra_sleep) |-> spi_cs_n;
  endproperty
  a_sleep_cs: assert property (p_sleep_cs) else $error("sleep entered mid frame");
  property p_ultra_loss;
    $rose(ultra_sleep) |-> buffer_lost && !buffer_valid;
  endproperty
  a_ultra_loss: assert property (p_ultra_loss) else $error("buffer kept in ultra");
  property p_loss_sticky;
    buffer_lost || !buffer_valid |=> !buffer_valid;
  endproperty
  a_loss_sticky: assert property (p_loss_sticky) else $error("buffer valid again");
  property p_busy_flag;
    array_busy |-> !ready;
  endproperty
  a_busy_flag: assert property (p_busy_flag) else $error("ready while busy");
  property p_standby;
    low_power_standby |-> ready && !deep_sleep && !ultra_sleep && $past(spi_cs_n, 2);
  endproperty
  a_standby: assert property (p_standby) else $error("standby flag wrong");
  property p_cfg_busy;
    s_prog_start |=> s_busy_hold;
  endproperty
  a_cfg_busy: assert property (p_cfg_busy) else $error("ready during program");
  property p_page_apply;
    !$past(rst, 2) && $changed(page_size_256) |-> page_size_256 == $past(nv_prog_val);
  endproperty
  a_page_apply: assert property (p_page_apply) else $error("page size off");
  property p_deep_locked;
    deep_sleep |=> !ultra_sleep && !nv_prog_stb;
  endproperty
  a_deep_locked: assert property (p_deep_locked) else $error("deep took command");
  property p_ultra_locked;
    ultra_sleep |=> !deep_sleep && !nv_prog_stb;
  endproperty
  a_ultra_locked: assert property (p_ultra_locked) else $error("ultra took command");
  property p_busy_refuse;
    array_busy [*8] |-> !nv_prog_stb;
  endproperty
  a_busy_refuse: assert property (p_busy_refuse) else $error("program while busy");
endmodule

bind fspc_top fspc_assertions i_chk (.clk_sys(clk_sys), .rst(rst), .spi_cs_n(spi_cs_n),
  .spi_so_oe_n(spi_so_oe_n), .array_busy(array_busy), .nv_prog_stb(nv_prog_stb),
  .nv_prog_val(nv_prog_val), .page_size_256(page_size_256), .ready(ready),
  .low_power_standby(low_power_standby), .deep_sleep(deep_sleep),
  .ultra_sleep(ultra_sleep), .buffer_lost(buffer_lost), .buffer_valid(buffer_valid));

//--- test/fspc_host.sv
`timescale 1ns/1ns
// ==========================================================
// Host link controller, mode 0, link clock 80 ns
module fspc_host (
  input wire logic clk_sys,
  output logic cs_n,
  output logic sck,
  output logic si,
  input wire logic so,
  input wire logic so_oe_n
);
  logic [15:0] rx;
  int drv;
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    rx = 16'h0000;
    drv = 0;
  end
  task automatic half(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // One framed transfer of n bits, MSB first; clock stands low outside frames
  task automatic frame(input logic [31:0] d, input int n);
    int i;
    drv = 0;
    cs_n <= 1'b0;
    half(10);
    for (i = 0; i < n; i++) begin
      si <= (i < 32) ? d[31-i] : 1'b0;
      half(10);
      sck <= 1'b1;
      // A floating output is read as the inverse of the last bit
      rx <= {rx[14:0], (so_oe_n === 1'b0) ? so : ~rx[0]};
      if (so_oe_n === 1'b0) begin
        drv++;
      end
      half(10);
      sck <= 1'b0;
    end
    half(10);
    cs_n <= 1'b1;
    si <= ~si; // Released line does not keep its value
    half(10);
  endtask
endmodule

//--- test/fspc_top_tb.sv
`timescale 1ns/1ns
module fspc_top_tb;
  // ==========================================================
  // Clock, reset, design and host
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  logic array_busy = 1'b0;
  logic nv_page_256 = 1'b0;
  logic spi_cs_n, spi_sck, spi_si, spi_so, spi_so_oe_n, nv_prog_stb, nv_prog_val;
  logic page_size_256, ready, low_power_standby, deep_sleep, ultra_sleep;
  logic buffer_lost, buffer_valid, pg, pt;
  logic [7:0] seed = 8'h47;
  logic [7:0] ops [2] = '{fspc_pkg::OP_DEEP_SLEEP, fspc_pkg::OP_ULTRA_SLEEP};
  logic [31:0] cfg = {fspc_pkg::OP_CFG_B0, fspc_pkg::OP_CFG_B1, fspc_pkg::OP_CFG_B2, 8'h00};
  int mismatches = 0;
  int checks_done = 0;
  int k;
  int stb_seen = 0;
  wire logic [15:0] st = {10'h000, deep_sleep, ultra_sleep, ready, buffer_valid,
    low_power_standby, page_size_256};
  always #2 clk_sys = ~clk_sys;
  // Program strobes, counted on the edge that samples them
  always @(posedge clk_sys) stb_seen <= stb_seen + int'(nv_prog_stb);
  fspc_top #(.T_DEEP_ENTRY_NS(200), .T_DEEP_EXIT_NS(200), .T_ULTRA_ENTRY_NS(200),
    .T_ULTRA_EXIT_NS(200), .T_CFG_PROG_NS(200)) i_dut (.clk_sys(clk_sys), .rst(rst),
    .clk_en(clk_en), .spi_cs_n(spi_cs_n), .spi_sck(spi_sck), .spi_si(spi_si),
    .spi_so(spi_so), .spi_so_oe_n(spi_so_oe_n), .array_busy(array_busy),
    .nv_page_256(nv_page_256), .nv_prog_stb(nv_prog_stb), .nv_prog_val(nv_prog_val),
    .page_size_256(page_size_256), .ready(ready), .low_power_standby(low_power_standby),
    .deep_sleep(deep_sleep), .ultra_sleep(ultra_sleep), .buffer_lost(buffer_lost),
    .buffer_valid(buffer_valid));
  fspc_host i_host (.clk_sys(clk_sys), .cs_n(spi_cs_n), .sck(spi_sck), .si(spi_si),
    .so(spi_so), .so_oe_n(spi_so_oe_n));
  // ==========================================================
  // Expectations and helpers
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic [15:0] exp_st(input logic d, u, r, v, l, p);
    return {10'h000, d, u, r, v, l, p};
  endfunction
  function automatic logic [15:0] exp_status(input logic rdy, input logic p256);
    return {rdy, 6'h00, p256, rdy, 7'h00};
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // Opcode with a random trailing byte that must be ignored
  task automatic op(input logic [7:0] o);
    seed = lfsr(seed);
    i_host.frame({o, seed, 16'h0000}, 16);
  endtask
  task automatic rd();
    i_host.frame({fspc_pkg::OP_STATUS_READ, 24'h000000}, 24);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Watchdog sized well above the expected run of some 12600 cycles
  initial begin
    idle(60000);
    mismatches++;
    final_report();
  end
  // ==========================================================
  // Scenarios
  initial begin
    pg = 1'b0;
    idle(10);
    rst <= 1'b0;
    idle(6);
    check(st, exp_st(0, 0, 1, 1, 1, 0));
    rd();
    check(i_host.rx, exp_status(1, 0));
    for (k = 0; k < 2; k++) begin
      i_host.frame({ops[k], 24'h000000}, 7);
      idle(70);
      check(st, exp_st(0, 0, 1, 1, 1, 0));
    end
    $display("test reset and partial entry done");
    op(fspc_pkg::OP_DEEP_SLEEP);
    idle(70);
    check(st, exp_st(1, 0, 1, 1, 0, 0));
    // Status, ultra entry and config must all bounce off deep sleep
    rd();
    check(16'(i_host.drv), 16'h0000);
    op(fspc_pkg::OP_ULTRA_SLEEP);
    i_host.frame(cfg | 32'h000000A6, 32);
    i_host.frame({fspc_pkg::OP_DEEP_WAKE, 24'h000000}, 7);
    idle(70);
    check(st, exp_st(1, 0, 1, 1, 0, 0));
    // A wake frame sent while the clock enable is low must leave no trace
    clk_en <= 1'b0;
    op(fspc_pkg::OP_DEEP_WAKE);
    clk_en <= 1'b1;
    idle(70);
    check(st, exp_st(1, 0, 1, 1, 0, 0));
    op(fspc_pkg::OP_DEEP_WAKE);
    idle(70);
    check(st, exp_st(0, 0, 1, 1, 1, 0));
    $display("test deep sleep done");
    op(fspc_pkg::OP_ULTRA_SLEEP);
    idle(70);
    check(st, exp_st(0, 1, 1, 0, 0, 0));
    // A status frame is the wake pulse; a config frame right after is too early
    rd();
    check(16'(i_host.drv), 16'h0000);
    i_host.frame(cfg | 32'h000000A6, 32);
    idle(70);
    check(st, exp_st(0, 0, 1, 0, 1, 0));
    $display("test ultra sleep done");
    // Size changes in both directions, then random targets
    for (k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      pt = (k < 2) ? ~pg : seed[0];
      i_host.frame(cfg | (pt ? 32'h000000A6 : 32'h000000A7), 32);
      idle(5);
      check(16'(ready), 16'h0000);
      check(16'(nv_prog_val), 16'(pt));
      check(16'(stb_seen), 16'(k + 1));
      idle(60);
      check(st, exp_st(0, 0, 1, 0, 1, pt));
      rd();
      check(i_host.rx, exp_status(1, pt));
      pg = pt;
    end
    $display("test page size done");
    array_busy <= 1'b1;
    idle(2);
    check(st, exp_st(0, 0, 0, 0, 0, pg));
    for (k = 0; k < 2; k++) begin
      op(ops[k]);
    end
    i_host.frame(cfg | (pg ? 32'h000000A7 : 32'h000000A6), 32);
    idle(70);
    check(st, exp_st(0, 0, 0, 0, 0, pg));
    check(16'(stb_seen), 16'h0004);
    array_busy <= 1'b0;
    idle(2);
    op(fspc_pkg::OP_DEEP_SLEEP);
    idle(70);
    check(st, exp_st(1, 0, 1, 0, 0, pg));
    $display("test busy refusal done");
    // Reset in deep sleep with the stored size at 256 bytes
    rst <= 1'b1;
    nv_page_256 <= 1'b1;
    idle(10);
    rst <= 1'b0;
    idle(6);
    check(st, exp_st(0, 0, 1, 1, 1, 1));
    $display("test second reset done");
    final_report();
  end
endmodule
